// ===== src/dis_slave.sv
// Contract
// - device is slave only, never clocks
// - works at standard, fast, high-speed rates
// - first byte after start is address
// - data captured on rising clock edge
// - data change during clock high: start/stop
// - clock line never held low
// - seven-bit addresses only, no ten-bit
// - general call acked, reset and wake
// - start is data falling, clock high
// - ninth clock: low acks, high nacks
// - ack own address, nack others
// - master restarts after an error
// - repeated start keeps the bus
// - repeated start detected like start
// - answers whichever master owns bus
// - stop is data rising; resets interface
// - address is fixed code plus three pins
// - high-speed code: nack, enter, leave at stop
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////
// receive buffer
module dis_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [W-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(D);
  localparam logic [AW:0] FULL = (AW + 1)'(D);

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } dis_fifo_st_t;

  dis_fifo_st_t q;
  dis_fifo_st_t n;
  logic [W-1:0] mem [D];
  logic push;
  logic pop;

  assign in_ready = q.cnt != FULL;
  assign out_valid = q.cnt != '0;
  assign out_data = mem[q.rp];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_comb begin
    n = q;
    if (push) begin
      n.wp = q.wp + 1'b1;
    end
    if (pop) begin
      n.rp = q.rp + 1'b1;
    end
    n.cnt = q.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
  end

  always_ff @(posedge clk) begin
    q <= reset ? '0 : n;
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[q.wp] <= in_data;
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////
// slave end
module dis_slave (
  input wire logic clk,
  input wire logic reset,
  dis_i2c_if.dev bus,
  input wire logic [2:0] addr_sel,
  output logic [dis_pkg::DATA_W-1:0] rx_data,
  output logic rx_first,
  output logic rx_valid,
  input wire logic rx_ready,
  input wire logic [dis_pkg::DATA_W-1:0] tx_data,
  output logic tx_taken,
  output logic selected,
  output logic hs_mode,
  output logic gc_reset,
  output logic gc_wake,
  output logic collision
);
  import dis_pkg::*;

  dis_slv_t q;
  dis_slv_t n;
  logic scl;
  logic sda;
  logic rise;
  logic fall;
  logic start;
  logic stop;
  logic push;
  logic push_ready;

  ////////////////////////////////////////////////////////////////////////////
  // line conditions
  assign scl = q.scl_sy[1];
  assign sda = q.sda_sy[1];
  assign rise = scl & ~q.scl_p;
  assign fall = ~scl & q.scl_p;
  assign start = scl & q.scl_p & q.sda_p & ~sda;
  assign stop = scl & q.scl_p & ~q.sda_p & sda;

  ////////////////////////////////////////////////////////////////////////////
  // byte engine
  always_comb begin
    n = q;
    push = 1'b0;
    n.gc_rst = 1'b0;
    n.gc_wake = 1'b0;
    n.coll = 1'b0;
    n.taken = 1'b0;
    // two-flop sync, fast enough for every rate
    n.scl_sy = {q.scl_sy[0], bus.scl};
    n.sda_sy = {q.sda_sy[0], bus.sda};
    n.scl_p = q.scl_sy[1];
    n.sda_p = q.sda_sy[1];
    if (start) begin
      // any master, any point of a frame
      n.st = SS_ADDR;
      n.bitn = 4'h0;
      n.drv = 1'b0;
      n.first = 1'b1;
    end else if (stop) begin
      n.st = SS_IDLE;
      n.drv = 1'b0;
      n.hs = 1'b0;
    end else if (rise && q.st != SS_IDLE) begin
      if (q.bitn < BITS_BYTE) begin
        n.sh = {q.sh[6:0], sda};
        n.bitn = q.bitn + 4'h1;
        if (q.st == SS_READ && !q.drv && !sda) begin
          n.st = SS_IDLE;
          n.coll = 1'b1;
        end
      end else if (q.bitn == BITS_BYTE) begin
        n.mack = sda;
        n.bitn = ACK_DONE;
      end
    end else if (fall && q.st != SS_IDLE) begin
      if (q.bitn == BITS_BYTE) begin
        n.drv = 1'b0;
        unique case (q.st)
          SS_ADDR: begin
            if (q.sh == GC_ADDR) begin
              n.drv = 1'b1;
              n.st = SS_GCMD;
            end else if (q.sh[7:1] == {ADDR_FIXED, addr_sel}) begin
              n.drv = 1'b1;
              n.st = q.sh[0] ? SS_READ : SS_WRITE;
            end else begin
              if (q.sh[7:3] == HS_CODE_TOP) begin
                n.hs = 1'b1;
              end
              n.st = SS_IGNORE;
            end
          end
          SS_GCMD: begin
            if (q.sh == GC_RESET) begin
              n.drv = 1'b1;
              n.gc_rst = 1'b1;
            end else if (q.sh == GC_WAKE) begin
              n.drv = 1'b1;
              n.gc_wake = 1'b1;
            end
            n.st = SS_IGNORE;
          end
          SS_WRITE: begin
            if (push_ready) begin
              n.drv = 1'b1;
              push = 1'b1;
              n.first = 1'b0;
            end
          end
          SS_IDLE, SS_READ, SS_IGNORE, SS_SPARE: begin
          end
        endcase
      end else if (q.bitn == ACK_DONE) begin
        n.drv = 1'b0;
        n.bitn = 4'h0;
        if (q.st == SS_READ) begin
          if (!q.mack) begin
            n.sh = tx_data;
            n.drv = ~tx_data[7];
            n.taken = 1'b1;
          end else begin
            n.st = SS_IGNORE;
          end
        end
      end else if (q.st == SS_READ) begin
        n.drv = ~q.sh[7];
      end
    end
  end

  always_ff @(posedge clk) begin
    q <= reset ? SLV_RST : n;
  end

  ////////////////////////////////////////////////////////////////////////////
  // receive path
  dis_fifo #(
    .W(DATA_W + 1),
    .D(FIFO_D)
  ) u_rx_fifo (
    .clk(clk),
    .reset(reset),
    .in_data({q.first, q.sh}),
    .in_valid(push),
    .in_ready(push_ready),
    .out_data({rx_first, rx_data}),
    .out_valid(rx_valid),
    .out_ready(rx_ready)
  );

  ////////////////////////////////////////////////////////////////////////////
  // outputs; the clock line is input only
  assign bus.sda_s_out = 1'b0;
  assign bus.sda_s_oe_n = ~q.drv;
  assign tx_taken = q.taken;
  assign selected = q.st == SS_READ || q.st == SS_WRITE;
  assign hs_mode = q.hs;
  assign gc_reset = q.gc_rst;
  assign gc_wake = q.gc_wake;
  assign collision = q.coll;
endmodule

// ===== shared/dis_pkg.sv
package dis_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int CLK_NS = 8;
  localparam int STD_KBPS = 100;
  localparam int FAST_KBPS = 400;
  localparam int HS_KBPS = 3400;
  // half bit period in clk cycles, rounded up (rate is a maximum)
  localparam int STD_HALF =
    ((1000000 + STD_KBPS - 1) / STD_KBPS + 2 * CLK_NS - 1) / (2 * CLK_NS);
  localparam int FAST_HALF =
    ((1000000 + FAST_KBPS - 1) / FAST_KBPS + 2 * CLK_NS - 1) / (2 * CLK_NS);
  localparam int HS_HALF =
    ((1000000 + HS_KBPS - 1) / HS_KBPS + 2 * CLK_NS - 1) / (2 * CLK_NS);

  ////////////////////////////////////////////////////////////////////////////
  // byte codes
  localparam logic [3:0] ADDR_FIXED = 4'hc;
  localparam logic [7:0] GC_ADDR = 8'h00;
  localparam logic [7:0] GC_RESET = 8'h06;
  localparam logic [7:0] GC_WAKE = 8'h09;
  localparam logic [4:0] HS_CODE_TOP = 5'h01;
  // arbitrary master id inside the high-speed code
  localparam logic [2:0] HS_MASTER_ID = 3'h1;
  localparam int DATA_W = 8;
  localparam int FIFO_D = 8;
  localparam logic [3:0] BITS_BYTE = 4'h8;
  localparam logic [3:0] ACK_DONE = 4'h9;

  typedef enum logic [1:0] {
    RATE_STD = 2'h0,
    RATE_FAST = 2'h1,
    RATE_HS = 2'h2
  } dis_rate_t;

  ////////////////////////////////////////////////////////////////////////////
  // slave end
  typedef enum logic [6:0] {
    SS_IDLE = 7'h01,
    SS_ADDR = 7'h02,
    SS_GCMD = 7'h04,
    SS_WRITE = 7'h08,
    SS_READ = 7'h10,
    SS_IGNORE = 7'h20,
    SS_SPARE = 7'h40
  } dis_sst_t;

  typedef struct packed {
    dis_sst_t st;
    logic [3:0] bitn;
    logic [7:0] sh;
    logic drv;
    logic mack;
    logic hs;
    logic first;
    logic [1:0] scl_sy;
    logic scl_p;
    logic [1:0] sda_sy;
    logic sda_p;
    logic gc_rst;
    logic gc_wake;
    logic coll;
    logic taken;
  } dis_slv_t;

  localparam dis_slv_t SLV_RST = '{st: SS_IDLE, bitn: 4'h0, sh: 8'h00,
    drv: 1'b0, mack: 1'b1, hs: 1'b0, first: 1'b0, scl_sy: 2'h3,
    scl_p: 1'b1, sda_sy: 2'h3, sda_p: 1'b1, gc_rst: 1'b0,
    gc_wake: 1'b0, coll: 1'b0, taken: 1'b0};

  ////////////////////////////////////////////////////////////////////////////
  // master end
  typedef enum logic [8:0] {
    MS_IDLE = 9'h001,
    MS_START = 9'h002,
    MS_BIT_LO = 9'h004,
    MS_BIT_HI = 9'h008,
    MS_RS_LO = 9'h010,
    MS_RS_HI = 9'h020,
    MS_P_LO = 9'h040,
    MS_P_HI = 9'h080,
    MS_P_END = 9'h100
  } dis_mst_st_t;

  typedef enum logic [1:0] {
    K_HSC = 2'h0,
    K_ADR = 2'h1,
    K_WRD = 2'h2,
    K_RDD = 2'h3
  } dis_kind_t;

  typedef struct packed {
    dis_mst_st_t st;
    logic [9:0] cnt;
    logic [3:0] bitn;
    logic [7:0] sh;
    dis_kind_t kind;
    dis_rate_t rate;
    logic hs;
    logic abort;
    logic [7:0] len;
    logic [6:0] addr;
    logic rd;
    logic [1:0] sda_sy;
    logic [7:0] rdata;
    logic rvalid;
    logic done;
    logic nack;
    logic sda_low;
    logic scl_low;
  } dis_mst_t;

  localparam dis_mst_t MST_RST = '{st: MS_IDLE, cnt: 10'h000, bitn: 4'h0,
    sh: 8'h00, kind: K_ADR, rate: RATE_STD, hs: 1'b0, abort: 1'b0,
    len: 8'h00, addr: 7'h00, rd: 1'b0, sda_sy: 2'h3, rdata: 8'h00,
    rvalid: 1'b0, done: 1'b0, nack: 1'b0, sda_low: 1'b0, scl_low: 1'b0};

endpackage

// ===== shared/dis_i2c_if.sv
`timescale 1ns/1ps
interface dis_i2c_if;
  logic scl_out;
  logic scl_oe_n;
  logic sda_m_out;
  logic sda_m_oe_n;
  logic sda_s_out;
  logic sda_s_oe_n;
  logic scl;
  logic sda;

  // open-drain wires with pull-up
  assign scl = scl_oe_n | scl_out;
  assign sda = (sda_m_oe_n | sda_m_out) & (sda_s_oe_n | sda_s_out);

  modport dev (
    input scl,
    input sda,
    output sda_s_out,
    output sda_s_oe_n
  );

  modport host (
    input sda,
    output scl_out,
    output scl_oe_n,
    output sda_m_out,
    output sda_m_oe_n
  );
endinterface

// ===== src/dis_master.sv
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////
// master end
module dis_master (
  input wire logic clk,
  input wire logic reset,
  dis_i2c_if.host bus,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [6:0] cmd_addr,
  input wire logic cmd_rd,
  input wire logic [7:0] cmd_len,
  input wire dis_pkg::dis_rate_t cmd_rate,
  input wire logic [7:0] wr_data,
  input wire logic wr_valid,
  output logic wr_ready,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic done,
  output logic nack
);
  import dis_pkg::*;

  dis_mst_t q;
  dis_mst_t n;
  logic tick;
  logic sda;
  logic take;

  function automatic logic [9:0] half_of(input dis_rate_t r, input logic hs);
    if (hs) begin
      return 10'(HS_HALF - 1);
    end else if (r == RATE_STD) begin
      return 10'(STD_HALF - 1);
    end
    return 10'(FAST_HALF - 1);
  endfunction

  assign tick = q.cnt == 10'h000;
  assign sda = q.sda_sy[1];

  always_comb begin
    n = q;
    take = 1'b0;
    n.done = 1'b0;
    n.rvalid = 1'b0;
    n.sda_sy = {q.sda_sy[0], bus.sda};
    unique case (q.st)
      MS_IDLE: begin
        if (cmd_valid) begin
          n.addr = cmd_addr;
          n.rd = cmd_rd;
          n.len = cmd_len;
          n.rate = cmd_rate;
          n.nack = 1'b0;
          n.abort = 1'b0;
          if (cmd_rate == RATE_HS && !q.hs) begin
            n.sh = {HS_CODE_TOP, HS_MASTER_ID};
            n.kind = K_HSC;
          end else begin
            n.sh = {cmd_addr, cmd_rd};
            n.kind = K_ADR;
          end
          n.st = MS_START;
        end
      end
      MS_START: begin
        if (tick) begin
          n.bitn = 4'h0;
          n.st = q.abort ? MS_P_END : MS_BIT_LO;
        end
      end
      MS_BIT_LO: begin
        if (tick) begin
          n.st = MS_BIT_HI;
        end
      end
      MS_BIT_HI: begin
        if (tick) begin
          n.st = MS_BIT_LO;
          if (q.bitn < BITS_BYTE) begin
            n.sh = {q.sh[6:0], sda};
            n.bitn = q.bitn + 4'h1;
          end else begin
            n.bitn = 4'h0;
            unique case (q.kind)
              K_HSC: begin
                n.hs = 1'b1;
                n.sh = {q.addr, q.rd};
                n.kind = K_ADR;
                n.st = MS_RS_LO;
              end
              K_ADR, K_WRD: begin
                if (sda) begin
                  n.nack = 1'b1;
                  n.abort = 1'b1;
                  n.st = MS_RS_LO;
                end else if (q.kind == K_ADR && q.rd) begin
                  n.kind = K_RDD;
                end else begin
                  if (q.kind == K_WRD) begin
                    n.len = q.len - 8'h01;
                  end
                  if (n.len != 8'h00 && wr_valid) begin
                    take = 1'b1;
                    n.sh = wr_data;
                    n.kind = K_WRD;
                  end else begin
                    n.st = MS_P_LO;
                  end
                end
              end
              K_RDD: begin
                n.rdata = q.sh;
                n.rvalid = 1'b1;
                n.len = q.len - 8'h01;
                if (q.len <= 8'h01) begin
                  n.st = MS_P_LO;
                end
              end
            endcase
          end
        end
      end
      MS_RS_LO: begin
        if (tick) begin
          n.st = MS_RS_HI;
        end
      end
      MS_RS_HI: begin
        if (tick) begin
          n.st = MS_START;
        end
      end
      MS_P_LO: begin
        if (tick) begin
          n.st = MS_P_HI;
        end
      end
      MS_P_HI: begin
        if (tick) begin
          n.st = MS_P_END;
        end
      end
      MS_P_END: begin
        if (tick) begin
          n.st = MS_IDLE;
          n.hs = 1'b0;
          n.done = 1'b1;
        end
      end
    endcase
    n.cnt = (tick || n.st != q.st) ? half_of(n.rate, n.hs) :
      q.cnt - 10'h001;
    n.scl_low = n.st == MS_BIT_LO || n.st == MS_RS_LO || n.st == MS_P_LO;
    // data follows the clock by one cycle, so data bits move only with clock low
    unique case (q.st)
      MS_START, MS_P_LO, MS_P_HI: begin
        n.sda_low = 1'b1;
      end
      MS_BIT_LO, MS_BIT_HI: begin
        n.sda_low = (q.bitn < BITS_BYTE) ?
          (q.kind != K_RDD && !q.sh[7]) : (q.kind == K_RDD && q.len > 8'h01);
      end
      MS_IDLE, MS_RS_LO, MS_RS_HI, MS_P_END: begin
        n.sda_low = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    q <= reset ? MST_RST : n;
  end

  assign bus.scl_out = 1'b0;
  assign bus.scl_oe_n = ~q.scl_low;
  assign bus.sda_m_out = 1'b0;
  assign bus.sda_m_oe_n = ~q.sda_low;
  assign cmd_ready = q.st == MS_IDLE;
  assign wr_ready = take;
  assign rd_data = q.rdata;
  assign rd_valid = q.rvalid;
  assign done = q.done;
  assign nack = q.nack;
endmodule

// ===== bench/dis_i2c_chk.sv
`timescale 1ns/1ps
module dis_i2c_chk (
  input wire logic clk,
  input wire logic reset,
  input wire logic scl_oe_n,
  input wire logic sda_s_out,
  input wire logic sda_s_oe_n,
  input wire logic scl,
  input wire logic sda
);
  import dis_pkg::*;
  logic scl_q, sda_q, idle_q, addr_q, rise, start, stop, nine;
  logic [3:0] bitc_q;
  logic [7:0] sh_q;

  ////////////////////////////////////////////////////////////////////////////
  // bus tracking
  assign rise = scl && !scl_q;
  assign start = scl && scl_q && sda_q && !sda;
  assign stop = scl && scl_q && !sda_q && sda;
  assign nine = rise && addr_q && bitc_q == BITS_BYTE;

  always_ff @(posedge clk) begin
    if (reset) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      idle_q <= 1'b1;
      addr_q <= 1'b0;
      bitc_q <= 4'h0;
      sh_q <= 8'h00;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      if (start) begin
        idle_q <= 1'b0;
        addr_q <= 1'b1;
        bitc_q <= 4'h0;
      end else if (stop) begin
        idle_q <= 1'b1;
      end else if (rise) begin
        if (bitc_q < BITS_BYTE) sh_q <= {sh_q[6:0], sda};
        bitc_q <= (bitc_q == ACK_DONE) ? 4'h1 : bitc_q + 4'h1;
        if (bitc_q == BITS_BYTE) addr_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // properties
  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  stable_drive_a: assert property ($changed(sda_s_oe_n) |-> !scl)
    else $error("slave data moved while clock high");
  open_drain_a: assert property (!sda_s_oe_n |-> !sda_s_out)
    else $error("slave drove data high");
  foreign_nack_a: assert property (nine && sh_q[7:4] != ADDR_FIXED
    && sh_q != GC_ADDR |-> sda) else $error("foreign address acked");
  hs_code_nack_a: assert property (nine && sh_q[7:3] == HS_CODE_TOP
    |-> sda && sda_s_oe_n) else $error("high-speed code acked");
  gc_ack_a: assert property ($fell(scl) && addr_q
    && bitc_q == BITS_BYTE && sh_q == GC_ADDR |-> ##[1:6] (!sda_s_oe_n) [*8])
    else $error("general call not acked");
  stop_idle_a: assert property (idle_q |-> sda_s_oe_n)
    else $error("slave drives after stop");
  addr_listen_a: assert property (addr_q && bitc_q < BITS_BYTE
    |-> sda_s_oe_n) else $error("slave drives during address");
  no_stretch_a: assert property (!scl |-> !scl_oe_n)
    else $error("clock held low by slave");
endmodule

// ===== bench/dis_tb_top.sv
`timescale 1ns/1ps
module dis_tb_top;
  import dis_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [2:0] addr_sel;
  logic rx_ready, cmd_valid, cmd_rd, wr_valid, rx_first, rx_valid, tx_taken;
  logic selected, hs_mode, gc_reset, gc_wake, collision, cmd_ready;
  logic wr_ready, rd_valid, done, nack;
  logic [7:0] tx_data, cmd_len, wr_data, rx_data, rd_data;
  logic [6:0] cmd_addr, own;
  dis_rate_t cmd_rate;
  logic [31:0] rxq[$], rdq[$], wq[$];
  logic [31:0] e;
  int fail_count = 0;
  int check_count = 0;
  int gcr = 0;
  int gcw = 0;

  dis_i2c_if link();
  dis_slave dis_slave_i (.clk(clk), .reset(reset), .bus(link),
    .addr_sel(addr_sel), .rx_data(rx_data), .rx_first(rx_first),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_data(tx_data),
    .tx_taken(tx_taken), .selected(selected), .hs_mode(hs_mode),
    .gc_reset(gc_reset), .gc_wake(gc_wake), .collision(collision));
  dis_master dis_master_i (.clk(clk), .reset(reset), .bus(link),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_addr(cmd_addr),
    .cmd_rd(cmd_rd), .cmd_len(cmd_len), .cmd_rate(cmd_rate),
    .wr_data(wr_data), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .rd_data(rd_data), .rd_valid(rd_valid), .done(done), .nack(nack));
  dis_i2c_chk dis_i2c_chk_i (.clk(clk), .reset(reset),
    .scl_oe_n(link.scl_oe_n), .sda_s_out(link.sda_s_out),
    .sda_s_oe_n(link.sda_s_oe_n), .scl(link.scl), .sda(link.sda));

  always #4 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////
  // reporting
  task automatic check(input string what, input logic [31:0] exp,
      input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // reference model
  always @(posedge clk) begin
    if (!reset && rx_valid && rx_ready) begin
      e = rxq.size() ? rxq.pop_front() : 32'hdead;
      check("rx byte", e, 32'({rx_first, rx_data}));
    end
    if (!reset && rd_valid) begin
      e = rdq.size() ? rdq.pop_front() : 32'hdead;
      check("read byte", e, 32'(rd_data));
    end
    if (collision === 1'b1) check("collision", 32'h0, 32'h1);
    if (gc_reset === 1'b1) gcr++;
    if (gc_wake === 1'b1) gcw++;
  end

  // next read byte offered after each load
  always @(negedge clk) begin
    if (reset || tx_taken === 1'b1) begin
      if (!reset) rdq.push_back(32'(tx_data));
      tx_data = 8'($urandom);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // one transfer
  task automatic xfer(input logic [6:0] a, input logic rd, input int n,
      input dis_rate_t rt, input logic en, input int keep);
    int i;
    int t;
    logic take, acc, hs_seen, sel_seen, fin;
    i = 0;
    take = 0;
    hs_seen = 0;
    sel_seen = 0;
    fin = 0;
    while (wq.size() < n) wq.push_back(32'($urandom_range(255)));
    for (t = 0; t < n && t < keep; t++)
      rxq.push_back({23'h0, 1'(t == 0), wq[t][7:0]});
    cmd_addr = a;
    cmd_rd = rd;
    cmd_len = 8'(n);
    cmd_rate = rt;
    cmd_valid = 1'b1;
    wr_data = wq[0][7:0];
    wr_valid = !rd;
    for (t = 0; t < 40000 && !fin; t++) begin
      acc = cmd_valid && cmd_ready;
      @(negedge clk);
      if (acc) cmd_valid = 1'b0;
      if (take) begin
        i++;
        wr_data = (i < n) ? wq[i][7:0] : 8'h00;
        wr_valid = (i < n) && !rd;
      end
      take = wr_ready;
      if (hs_mode === 1'b1) hs_seen = 1'b1;
      if (selected === 1'b1) sel_seen = 1'b1;
      fin = (done === 1'b1);
    end
    if (!fin) begin
      check("timeout", 32'h0, 32'h1);
      give_verdict();
    end
    repeat (4) @(negedge clk);
    check("nack", 32'(en), 32'(nack));
    check("hs seen", 32'(rt == RATE_HS), 32'(hs_seen));
    check("hs after stop", 32'h0, 32'(hs_mode));
    check("selected", 32'(a == own), 32'(sel_seen));
    wq.delete();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  initial begin
    void'($urandom(32'h5f57));
    addr_sel = 3'($urandom);
    own = {ADDR_FIXED, addr_sel};
    rx_ready = 1'b1;
    cmd_valid = 1'b0;
    cmd_addr = 7'h00;
    cmd_rd = 1'b0;
    cmd_len = 8'h00;
    cmd_rate = RATE_STD;
    wr_data = 8'h00;
    wr_valid = 1'b0;
    repeat (6) @(negedge clk);
    reset = 1'b0;
    for (int k = 0; k < 3; k++) xfer(own, 0, 1, dis_rate_t'(k), 0, 8);
    xfer(own ^ 7'h05, 0, 2, RATE_FAST, 1, 0);
    xfer(own, 1, 3, RATE_HS, 0, 0);
    for (int k = 0; k < 2; k++) begin
      wq.push_back(32'(k ? GC_WAKE : GC_RESET));
      wq.push_back(32'(k ? GC_WAKE : GC_RESET));
      xfer(7'h00, 0, 2, RATE_HS, 1, 0);
    end
    check("gc reset pulses", 32'h1, 32'(gcr));
    check("gc wake pulses", 32'h1, 32'(gcw));
    rx_ready = 1'b0;
    xfer(own, 0, 10, RATE_HS, 1, FIFO_D);
    check("fifo full", 32'h1, 32'(rx_valid));
    rx_ready = 1'b1;
    repeat (FIFO_D + 4) @(negedge clk);
    check("rx left", 32'h0, 32'(rxq.size()));
    check("read left", 32'h0, 32'(rdq.size()));
    give_verdict();
  end
endmodule
